/* File: bench/ccs_host_model.sv */
// Register-port host model: one-cycle strobes, read data taken in the following cycle
`timescale 1ns/10ps
module ccs_host_model
   import ccs_pkg::*;
(
   input  wire logic              clk,
   output logic      [3:0]        regAddr,
   output logic      [CCS_DW-1:0] regWrData,
   output logic                   regWr,
   output logic                   regRd,
   input  wire logic [CCS_DW-1:0] regRdData
);
   // Idle bus at time zero
   initial begin
      regAddr   = 4'h0;
      regWrData = 16'h0000;
      regWr     = 1'b0;
      regRd     = 1'b0;
   end

   // Write; released data is inverted so a stale value can never be mistaken for a fresh one
   task automatic wr(input logic [3:0] a, input logic [CCS_DW-1:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk);
      regWr     <= 1'b0;
      regWrData <= ~d;
   endtask : wr

   // Read; data stands only in the cycle after the strobe, so it is taken just after that edge
   task automatic rd(input logic [3:0] a, output logic [CCS_DW-1:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      #1;
      d = regRdData;
   endtask : rd
endmodule : ccs_host_model

/* File: bench/tb_ccs_loader.sv */
// Self-checking bench for the coefficient shadow loader
`timescale 1ns/10ps
module tb_ccs_loader;
   import ccs_pkg::*;
   localparam int L = 17;
   logic                        clk;
   logic                        rst;
   logic [3:0]                  regAddr;
   logic [CCS_DW-1:0]           regWrData;
   logic                        regWr;
   logic                        regRd;
   logic [CCS_DW-1:0]           regRdData;
   logic                        timerEvent;
   logic                        syncA;
   logic                        syncB;
   logic [CCS_RAMS*9-1:0]       rdPhase;
   logic [CCS_RAMS*2-1:0]       rdSeg;
   logic [CCS_RAMS-1:0]         rdImag;
   logic [CCS_RAMS*CCS_DW-1:0]  rdData;
   logic [CCS_RAMS-1:0]         ramInService;
   logic [7:0]                  peakLag;
   logic                        irq;
   int                          failures;
   int                          checks_done;
   int                          cycles;
   int                          nReal;
   logic [15:0]                 d;

   ccs_loader ccs_loader_inst (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .timerEvent(timerEvent), .syncA(syncA),
      .syncB(syncB), .rdPhase(rdPhase), .rdSeg(rdSeg), .rdImag(rdImag), .rdData(rdData),
      .ramInService(ramInService), .peakLag(peakLag), .irq(irq));
   ccs_host_model ccs_host_model_inst (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

   // Clock and hang guard; ceiling covers the fill plus all copies with wide margin
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

   function automatic logic [15:0] pat(input int a);
      return 16'hc000 ^ 16'(a * 5);
   endfunction : pat

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      ccs_host_model_inst.wr(a, v);
   endtask : wr

   // Bounded wait for the completion interrupt
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(16'(irq), 16'h0001);
   endtask : wait_irq

   // Acknowledge done; the level interrupt must drop with it
   task automatic clear_done();
      wr(CCS_REG_STATUS, 16'h0040);
      repeat (2) @(posedge clk);
      #1;
      check(16'(irq), 16'h0000);
      ccs_host_model_inst.rd(CCS_REG_STATUS, d);
      check(d & 16'h0040, 16'h0000);
   endtask : clear_done

   // Armed soft-triggered copy into the masked RAMs, returning cycles to interrupt
   task automatic copy(input logic [15:0] m, output int n);
      wr(CCS_REG_MASK, m);
      wr(CCS_REG_INTMSK, 16'h0040);
      wr(CCS_REG_TRIG, 16'(CCS_TRIG_SOFT));
      wr(CCS_REG_SOFT, 16'h0001);
      wait_irq(n);
      clear_done();
   endtask : copy

   // One canceler read through RAM g
   task automatic rchk(input int g, input int ph, input int sg, input logic im, input logic [15:0] exp);
      @(posedge clk);
      rdPhase[g*9+:9] <= 9'(ph);
      rdSeg[g*2+:2]   <= 2'(sg);
      rdImag[g]       <= im;
      @(posedge clk);
      #1;
      check(rdData[g*CCS_DW+:CCS_DW], exp);
   endtask : rchk

   task automatic t_reset();
      ccs_host_model_inst.rd(CCS_REG_LENGTH, d);
      check(d, 16'(CCS_RST_LENGTH));
      ccs_host_model_inst.rd(CCS_REG_STATUS, d);
      check(d, 16'h0000);
      check(16'(peakLag), 16'(CCS_RST_LAG));
      check(16'(ramInService), 16'h0000);
      wr(CCS_REG_LAG, 16'(L / 2));
      repeat (2) @(posedge clk);
      check(16'(peakLag), 16'(L / 2));
      $display("test reset done");
   endtask : t_reset

   // Whole shadow through the window, reverse-order pointer loads, out-of-range pointer
   task automatic t_window();
      wr(CCS_REG_PTR, 16'h0000);
      for (int a = 0; a < 768; a++) wr(CCS_REG_DATA, pat(a));
      wr(CCS_REG_PTR, 16'h0000);
      for (int a = 0; a < 3; a++) begin
         ccs_host_model_inst.rd(CCS_REG_DATA, d);
         check(d, pat(a));
      end
      wr(CCS_REG_PTR, 16'h0002);
      wr(CCS_REG_DATA, 16'h0321);
      wr(CCS_REG_PTR, 16'h0001);
      wr(CCS_REG_DATA, 16'h0456);
      wr(CCS_REG_PTR, 16'h0000);
      wr(CCS_REG_DATA, 16'h0111);
      ccs_host_model_inst.rd(CCS_REG_DATA, d);
      check(d, 16'h0456);
      ccs_host_model_inst.rd(CCS_REG_DATA, d);
      check(d, 16'h0321);
      wr(CCS_REG_PTR, 16'h02ff);
      wr(CCS_REG_DATA, 16'hbeef);
      wr(CCS_REG_DATA, 16'hdead);
      ccs_host_model_inst.rd(CCS_REG_DATA, d);
      check(d, 16'h0000);
      wr(CCS_REG_PTR, 16'h02ff);
      ccs_host_model_inst.rd(CCS_REG_DATA, d);
      check(d, 16'hbeef);
      ccs_host_model_inst.rd(4'hf, d);
      check(d, 16'h0000);
      // Restore the pattern at the touched places
      wr(CCS_REG_PTR, 16'h0000);
      for (int a = 0; a < 3; a++) wr(CCS_REG_DATA, pat(a));
      wr(CCS_REG_PTR, 16'h02ff);
      wr(CCS_REG_DATA, pat(767));
      $display("test window done");
   endtask : t_window

   task automatic t_copy_real();
      int n;
      wr(CCS_REG_LENGTH, 16'(L));
      wr(CCS_REG_FORMAT, 16'(CCS_FMT_REAL_UNIQUE));
      copy(16'h0005, nReal);
      check(16'(nReal >= 3 * L && nReal <= 3 * L + 6), 16'h0001);
      for (int s = 0; s < 3; s++) begin
         rchk(0, 0, s, 1'b0, pat(s * 256));
         rchk(2, L - 1, s, 1'b0, pat(s * 256 + L - 1));
      end
      copy(16'h00ff, n);
      check(16'(n), 16'(nReal));
      // A window write must not reach a canceler RAM
      wr(CCS_REG_PTR, 16'h0000);
      wr(CCS_REG_DATA, 16'h1234);
      rchk(0, 0, 0, 1'b0, pat(0));
      wr(CCS_REG_PTR, 16'h0000);
      wr(CCS_REG_DATA, pat(0));
      $display("test copy real done");
   endtask : t_copy_real

   task automatic t_mirror();
      wr(CCS_REG_FORMAT, 16'(CCS_FMT_REAL_MIRROR));
      rchk(0, L - 1, 0, 1'b0, pat(L - 1));
      rchk(0, L, 1, 1'b0, pat(256 + L - 2));
      rchk(0, 2 * L - 2, 2, 1'b0, pat(512));
      $display("test mirror done");
   endtask : t_mirror

   task automatic t_complex();
      int n;
      wr(CCS_REG_FORMAT, 16'(CCS_FMT_COMPLEX));
      copy(16'h0002, n);
      check(16'(n), 16'(nReal + 3 * L));
      for (int s = 0; s < 3; s++) begin
         rchk(1, 0, s, 1'b1, pat(s * 256 + 128));
         rchk(1, L - 1, s, 1'b0, pat(s * 256 + L - 1));
      end
      wr(CCS_REG_FORMAT, 16'(CCS_FMT_REAL_UNIQUE));
      $display("test complex done");
   endtask : t_complex

   // Copy must hold off while a selected RAM is still in service
   task automatic t_wait_idle();
      int n;
      wr(CCS_REG_STAGE, 16'h0121);
      repeat (3) @(posedge clk);
      check(16'(ramInService), 16'h000f);
      wr(CCS_REG_MASK, 16'h0001);
      wr(CCS_REG_INTMSK, 16'h0040);
      wr(CCS_REG_TRIG, 16'(CCS_TRIG_SOFT));
      wr(CCS_REG_SOFT, 16'h0001);
      repeat (3 * L + 20) @(posedge clk);
      check(16'(irq), 16'h0000);
      wr(CCS_REG_STAGE, 16'h0000);
      wait_irq(n);
      check(16'(ramInService), 16'h0000);
      clear_done();
      $display("test wait idle done");
   endtask : t_wait_idle

   // Each hardware source starts the copy; a source not selected is ignored
   task automatic t_sources();
      int n;
      wr(CCS_REG_INTMSK, 16'h0040);
      for (int s = 1; s < 4; s++) begin
         wr(CCS_REG_TRIG, 16'(s));
         pulse(s == 3 ? 1 : s + 1);
         repeat (3 * L + 20) @(posedge clk);
         check(16'(irq), 16'h0000);
         pulse(s);
         wait_irq(n);
         clear_done();
      end
      // Interrupt not armed: flag only
      wr(CCS_REG_INTMSK, 16'h0000);
      wr(CCS_REG_TRIG, 16'(CCS_TRIG_SOFT));
      wr(CCS_REG_SOFT, 16'h0001);
      repeat (3 * L + 20) @(posedge clk);
      check(16'(irq), 16'h0000);
      ccs_host_model_inst.rd(CCS_REG_STATUS, d);
      check(d & 16'h0040, 16'h0040);
      clear_done();
      $display("test sources done");
   endtask : t_sources

   task automatic pulse(input int s);
      @(posedge clk);
      timerEvent <= (s == 1);
      syncA      <= (s == 2);
      syncB      <= (s == 3);
      @(posedge clk);
      timerEvent <= 1'b0;
      syncA      <= 1'b0;
      syncB      <= 1'b0;
   endtask : pulse

   // Main sequence
   initial begin
      clk         = 1'b0;
      rst         = 1'b1;
      timerEvent  = 1'b0;
      syncA       = 1'b0;
      syncB       = 1'b0;
      rdPhase     = '0;
      rdSeg       = '0;
      rdImag      = '0;
      failures    = 0;
      checks_done = 0;
      cycles      = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_window();
      t_copy_real();
      t_mirror();
      t_complex();
      t_wait_idle();
      t_sources();
      final_report();
   end
endmodule : tb_ccs_loader

/* File: hw/ccs_canceler_ram.sv */
// One canceler RAM: copy-only write port, one registered read per internal clock
`timescale 1ns/10ps
module ccs_canceler_ram
   import ccs_pkg::*;
#(
   parameter int unsigned INDEX = 0
) (
   input  wire logic                clk,
   input  wire logic                rst,
   ccs_ram_if.ram                   wr,
   input  wire logic [8:0]          rdPhase,
   input  wire logic [1:0]          rdSeg,
   input  wire logic                rdImag,
   output logic      [CCS_DW-1:0]   rdData
);
   typedef struct packed {
      logic [767:0][CCS_DW-1:0] mem;
      logic [CCS_DW-1:0]        rdData;
   } ccs_ram_state_t;

   ccs_ram_state_t s_ff;
   ccs_ram_state_t nxt_s;
   logic [7:0]     tap;
   logic [9:0]     rdAddr;

   // Read address follows the same layout as the shadow memory
   always_comb begin
      nxt_s = s_ff;
      tap   = ccs_tap_of(rdPhase, wr.length, wr.format == CCS_FMT_REAL_MIRROR);
      if (wr.format == CCS_FMT_COMPLEX)
         rdAddr = {rdSeg, rdImag, tap[6:0]};
      else
         rdAddr = {rdSeg, tap};
      if (rdAddr <= CCS_LAST_ADDR)
         nxt_s.rdData = s_ff.mem[rdAddr];
      else
         nxt_s.rdData = '0;
      // Only the loader writes here, never the register port
      if (wr.wrSel[INDEX])
         nxt_s.mem[wr.wrAddr] = wr.wrData;
   end

   // Contents need no reset; only the read register is cleared
   always_ff @(posedge clk) begin
      s_ff <= nxt_s;
      if (rst)
         s_ff.rdData <= '0;
   end

   assign rdData = s_ff.rdData;
endmodule : ccs_canceler_ram

/* File: hw/ccs_loader.sv */
// Coefficient shadow memory, register port and copy engine into eight canceler RAMs
`timescale 1ns/10ps
module ccs_loader
   import ccs_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic [3:0]               regAddr,
   input  wire logic [CCS_DW-1:0]        regWrData,
   input  wire logic                     regWr,
   input  wire logic                     regRd,
   output logic      [CCS_DW-1:0]        regRdData,
   input  wire logic                     timerEvent,
   input  wire logic                     syncA,
   input  wire logic                     syncB,
   input  wire logic [CCS_RAMS*9-1:0]    rdPhase,
   input  wire logic [CCS_RAMS*2-1:0]    rdSeg,
   input  wire logic [CCS_RAMS-1:0]      rdImag,
   output logic      [CCS_RAMS*CCS_DW-1:0] rdData,
   output logic      [CCS_RAMS-1:0]      ramInService,
   output logic      [7:0]               peakLag,
   output logic                          irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_WAIT, ST_COPY} ccs_state_t;

   typedef struct packed {
      logic [767:0][CCS_DW-1:0] shadow;
      logic [CCS_AW-1:0]        ptr;
      logic [1:0]               format;
      logic [7:0]               length;
      logic [7:0]               lag;
      logic [CCS_RAMS-1:0]      mask;
      logic [1:0]               trigSel;
      logic [15:0]              stage;
      logic                     intMask;
      logic                     intArmed;
      logic                     done;
      ccs_state_t               state;
      logic [1:0]               seg;
      logic [7:0]               tap;
      logic                     imag;
      logic [CCS_RAMS-1:0]      wrSel;
      logic [CCS_AW-1:0]        wrAddr;
      logic [CCS_DW-1:0]        wrData;
      logic [CCS_RAMS-1:0]      inService;
      logic [CCS_DW-1:0]        rdData;
      logic                     irq;
   } ccs_state_s_t;

   ccs_state_s_t s_ff;
   ccs_state_s_t nxt_s;
   logic         winAcc;
   logic         winOk;
   logic         event_;
   logic         lastVal;
   logic [9:0]   srcAddr;
   logic [5:0]   ramTotal;
   ccs_ram_if    ramBus ();

   // Stage counts are four nibbles; their sum gives the RAMs in service
   // Sum kept wide so an over-allocated total never wraps back to a small count
   always_comb begin
      ramTotal = 6'(s_ff.stage[3:0]) + 6'(s_ff.stage[7:4]) + 6'(s_ff.stage[11:8]) + 6'(s_ff.stage[15:12]);
   end

   // Trigger mux and copy addressing
   always_comb begin
      unique case (s_ff.trigSel)
         CCS_TRIG_SOFT:  event_ = regWr && (regAddr == CCS_REG_SOFT) && regWrData[0];
         CCS_TRIG_TIMER: event_ = timerEvent;
         CCS_TRIG_SYNCA: event_ = syncA;
         CCS_TRIG_SYNCB: event_ = syncB;
      endcase
      if (s_ff.format == CCS_FMT_COMPLEX)
         srcAddr = {s_ff.seg, s_ff.imag, s_ff.tap[6:0]};
      else
         srcAddr = {s_ff.seg, s_ff.tap};
      lastVal = (s_ff.seg == CCS_LAST_SEG) && (s_ff.tap == s_ff.length - 8'h01)
                && (s_ff.imag || (s_ff.format != CCS_FMT_COMPLEX));
      winAcc = (regWr || regRd) && (regAddr == CCS_REG_DATA);
      winOk  = s_ff.ptr <= CCS_LAST_ADDR;
   end

   // Register port, shadow memory and copy sequencer
   always_comb begin
      nxt_s        = s_ff;
      nxt_s.wrSel  = '0;
      nxt_s.rdData = '0;
      nxt_s.irq    = s_ff.done && s_ff.intArmed;
      for (int i = 0; i < CCS_RAMS; i++)
         nxt_s.inService[i] = 6'(i) < ramTotal;
      if (regWr) begin
         unique case (regAddr)
            CCS_REG_PTR:    nxt_s.ptr     = regWrData[CCS_AW-1:0];
            CCS_REG_DATA:   if (winOk) nxt_s.shadow[s_ff.ptr] = regWrData;
            CCS_REG_FORMAT: nxt_s.format  = regWrData[1:0];
            CCS_REG_LENGTH: nxt_s.length  = regWrData[7:0];
            CCS_REG_LAG:    nxt_s.lag     = regWrData[7:0];
            CCS_REG_MASK:   nxt_s.mask    = regWrData[CCS_RAMS-1:0];
            CCS_REG_TRIG: begin
               nxt_s.trigSel  = regWrData[1:0];
               nxt_s.intArmed = s_ff.intMask;
               if (s_ff.state == ST_IDLE)
                  nxt_s.state = ST_ARMED;
            end
            CCS_REG_STATUS: if (regWrData[CCS_DONE_BIT]) nxt_s.done = 1'b0;
            CCS_REG_INTMSK: nxt_s.intMask = regWrData[CCS_DONE_BIT];
            CCS_REG_STAGE:  nxt_s.stage   = regWrData;
            default: ;
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            CCS_REG_PTR:    nxt_s.rdData = CCS_DW'(s_ff.ptr);
            CCS_REG_DATA:   nxt_s.rdData = winOk ? s_ff.shadow[s_ff.ptr] : '0;
            CCS_REG_FORMAT: nxt_s.rdData = CCS_DW'(s_ff.format);
            CCS_REG_LENGTH: nxt_s.rdData = CCS_DW'(s_ff.length);
            CCS_REG_LAG:    nxt_s.rdData = CCS_DW'(s_ff.lag);
            CCS_REG_MASK:   nxt_s.rdData = CCS_DW'(s_ff.mask);
            CCS_REG_TRIG:   nxt_s.rdData = CCS_DW'(s_ff.trigSel);
            CCS_REG_STATUS: begin
               nxt_s.rdData[CCS_DONE_BIT] = s_ff.done;
               nxt_s.rdData[CCS_BUSY_BIT] = s_ff.state != ST_IDLE;
            end
            CCS_REG_INTMSK: nxt_s.rdData[CCS_DONE_BIT] = s_ff.intMask;
            CCS_REG_STAGE:  nxt_s.rdData = s_ff.stage;
            default:        nxt_s.rdData = '0;
         endcase
      end
      // Pointer moves after the window access; an out-of-range access leaves it alone
      if (winAcc && winOk && !(regWr && regAddr == CCS_REG_PTR))
         nxt_s.ptr = s_ff.ptr + 10'h001;
      unique case (s_ff.state)
         ST_IDLE: ;
         ST_ARMED: if (event_) begin
            nxt_s.state = ST_WAIT;
            nxt_s.seg   = '0;
            nxt_s.tap   = '0;
            nxt_s.imag  = 1'b0;
         end
         // Selected RAMs must be out of service first, so live cancelers never see a half-loaded pulse
         ST_WAIT: if ((s_ff.mask & s_ff.inService) == '0)
            nxt_s.state = ST_COPY;
         ST_COPY: begin
            nxt_s.wrSel  = s_ff.mask;
            nxt_s.wrAddr = srcAddr;
            nxt_s.wrData = s_ff.shadow[srcAddr];
            if (s_ff.format == CCS_FMT_COMPLEX && !s_ff.imag)
               nxt_s.imag = 1'b1;
            else begin
               nxt_s.imag = 1'b0;
               if (s_ff.tap == s_ff.length - 8'h01) begin
                  nxt_s.tap = '0;
                  nxt_s.seg = s_ff.seg + 2'h1;
               end else
                  nxt_s.tap = s_ff.tap + 8'h01;
            end
            if (lastVal) begin
               nxt_s.state = ST_IDLE;
               nxt_s.done  = 1'b1;
            end
         end
      endcase
   end

   // One register for all state; control fields reset, memory contents do not
   always_ff @(posedge clk) begin
      s_ff <= nxt_s;
      if (rst) begin
         s_ff.ptr       <= '0;
         s_ff.format    <= CCS_FMT_REAL_UNIQUE;
         s_ff.length    <= CCS_RST_LENGTH;
         s_ff.lag       <= CCS_RST_LAG;
         s_ff.mask      <= CCS_RST_MASK;
         s_ff.trigSel   <= CCS_TRIG_SOFT;
         s_ff.stage     <= CCS_RST_STAGE;
         s_ff.intMask   <= 1'b0;
         s_ff.intArmed  <= 1'b0;
         s_ff.done      <= 1'b0;
         s_ff.state     <= ST_IDLE;
         s_ff.seg       <= '0;
         s_ff.tap       <= '0;
         s_ff.imag      <= 1'b0;
         s_ff.wrSel     <= '0;
         s_ff.wrAddr    <= '0;
         s_ff.wrData    <= '0;
         s_ff.inService <= '0;
         s_ff.rdData    <= '0;
         s_ff.irq       <= 1'b0;
      end
   end

   assign regRdData      = s_ff.rdData;
   assign ramInService   = s_ff.inService;
   assign peakLag        = s_ff.lag;
   assign irq            = s_ff.irq;
   assign ramBus.wrSel   = s_ff.wrSel;
   assign ramBus.wrAddr  = s_ff.wrAddr;
   assign ramBus.wrData  = s_ff.wrData;
   assign ramBus.format  = s_ff.format;
   assign ramBus.length  = s_ff.length;

   // Eight identical canceler RAMs share the broadcast write path
   for (genvar g = 0; g < CCS_RAMS; g++) begin : gRam
      ccs_canceler_ram #(.INDEX(g)) uRam (
         .clk     (clk),
         .rst     (rst),
         .wr      (ramBus.ram),
         .rdPhase (rdPhase[g*9 +: 9]),
         .rdSeg   (rdSeg[g*2 +: 2]),
         .rdImag  (rdImag[g]),
         .rdData  (rdData[g*CCS_DW +: CCS_DW])
      );
   end

   // Checks
   sequence winWrite_s;
      regWr && regAddr == CCS_REG_DATA && s_ff.ptr <= CCS_LAST_ADDR;
   endsequence

   sequence winRead_s;
      regRd && regAddr == CCS_REG_DATA && s_ff.ptr <= CCS_LAST_ADDR;
   endsequence

   // Waiting on a selected RAM that is still live, or free to start the copy
   sequence waitBlocked_s;
      s_ff.state == ST_WAIT && (s_ff.mask & s_ff.inService) != '0;
   endsequence

   sequence waitFree_s;
      s_ff.state == ST_WAIT && (s_ff.mask & s_ff.inService) == '0;
   endsequence

   ptr_increment_a: assert property (@(posedge clk) disable iff (rst)
      winWrite_s |=> s_ff.ptr == $past(s_ff.ptr) + 10'h001)
      else $error("pointer did not advance after window write");

   window_store_a: assert property (@(posedge clk) disable iff (rst)
      winWrite_s |=> s_ff.shadow[$past(s_ff.ptr)] == $past(regWrData))
      else $error("window write not stored in shadow memory");

   bad_ptr_a: assert property (@(posedge clk) disable iff (rst)
      (regRd && regAddr == CCS_REG_DATA && s_ff.ptr > CCS_LAST_ADDR)
      |=> regRdData == '0 && s_ff.ptr == $past(s_ff.ptr))
      else $error("out-of-range window access had an effect");

   ptr_reload_a: assert property (@(posedge clk) disable iff (rst)
      (regWr && regAddr == CCS_REG_PTR) |=> s_ff.ptr == $past(regWrData[CCS_AW-1:0]))
      else $error("pointer reload not honoured");

   idle_wait_a: assert property (@(posedge clk) disable iff (rst)
      waitBlocked_s |=> s_ff.state == ST_WAIT && s_ff.wrSel == '0)
      else $error("copy reached a RAM still in service");

   wait_release_a: assert property (@(posedge clk) disable iff (rst)
      waitFree_s |=> s_ff.state == ST_COPY)
      else $error("copy did not start once selected RAMs were idle");

   mask_bcast_a: assert property (@(posedge clk) disable iff (rst)
      s_ff.state == ST_COPY |=> s_ff.wrSel == $past(s_ff.mask))
      else $error("copy write not broadcast to masked RAMs");

   done_set_a: assert property (@(posedge clk) disable iff (rst)
      (s_ff.state == ST_COPY && lastVal) |=> s_ff.done ##1 (s_ff.irq == $past(s_ff.intArmed)))
      else $error("completion flag or interrupt wrong after last value");

   real_addr_a: assert property (@(posedge clk) disable iff (rst)
      (s_ff.state == ST_COPY && s_ff.format != CCS_FMT_COMPLEX)
      |=> s_ff.wrAddr == {$past(s_ff.seg), $past(s_ff.tap)})
      else $error("real copy address wrong");

   cplx_pair_a: assert property (@(posedge clk) disable iff (rst)
      (s_ff.state == ST_COPY && s_ff.format == CCS_FMT_COMPLEX && !s_ff.imag)
      |=> s_ff.wrAddr[7] == 1'b0 ##1 s_ff.wrAddr[7] == 1'b1)
      else $error("complex real/imag pair order wrong");

   lag_out_a: assert property (@(posedge clk) disable iff (rst)
      (regWr && regAddr == CCS_REG_LAG) |=> peakLag == $past(regWrData[7:0]))
      else $error("peak lag not forwarded");

   ptr_read_a: assert property (@(posedge clk) disable iff (rst)
      winRead_s |=> s_ff.ptr == $past(s_ff.ptr) + 10'h001)
      else $error("pointer did not advance after window read");

   arm_latch_a: assert property (@(posedge clk) disable iff (rst)
      (regWr && regAddr == CCS_REG_TRIG && s_ff.state == ST_IDLE)
      |=> s_ff.state == ST_ARMED && s_ff.intArmed == $past(s_ff.intMask))
      else $error("trigger write did not arm or latch the interrupt mask");

   done_clear_a: assert property (@(posedge clk) disable iff (rst)
      (regWr && regAddr == CCS_REG_STATUS && regWrData[CCS_DONE_BIT] && !(s_ff.state == ST_COPY && lastVal))
      |=> !s_ff.done)
      else $error("completion flag not cleared by acknowledge");
endmodule : ccs_loader

/* File: hw/ccs_pkg.sv */
// Constants, register map and helpers for the coefficient shadow loader
package ccs_pkg;
   // Storage geometry
   localparam int unsigned CCS_DW         = 16;
   localparam int unsigned CCS_AW         = 10;
   localparam int unsigned CCS_RAMS       = 8;
   localparam logic [9:0]  CCS_LAST_ADDR  = 10'h2ff;
   localparam logic [9:0]  CCS_IMAG_OFS   = 10'h080;
   localparam logic [9:0]  CCS_DERIV1_BASE = 10'h100;
   localparam logic [9:0]  CCS_DERIV2_BASE = 10'h200;
   localparam logic [1:0]  CCS_LAST_SEG   = 2'h2;
   localparam logic [3:0]  CCS_MAX_RAMS   = 4'h8;

   // Register indices on the plain register port
   localparam logic [3:0]  CCS_REG_PTR    = 4'h0;
   localparam logic [3:0]  CCS_REG_DATA   = 4'h1;
   localparam logic [3:0]  CCS_REG_FORMAT = 4'h2;
   localparam logic [3:0]  CCS_REG_LENGTH = 4'h3;
   localparam logic [3:0]  CCS_REG_LAG    = 4'h4;
   localparam logic [3:0]  CCS_REG_MASK   = 4'h5;
   localparam logic [3:0]  CCS_REG_TRIG   = 4'h6;
   localparam logic [3:0]  CCS_REG_SOFT   = 4'h7;
   localparam logic [3:0]  CCS_REG_STATUS = 4'h8;
   localparam logic [3:0]  CCS_REG_INTMSK = 4'h9;
   localparam logic [3:0]  CCS_REG_STAGE  = 4'ha;

   // Field positions and codes
   localparam int unsigned CCS_DONE_BIT   = 6;
   localparam int unsigned CCS_BUSY_BIT   = 0;
   localparam logic [1:0]  CCS_FMT_REAL_UNIQUE = 2'h0;
   localparam logic [1:0]  CCS_FMT_REAL_MIRROR = 2'h1;
   localparam logic [1:0]  CCS_FMT_COMPLEX     = 2'h2;
   localparam logic [1:0]  CCS_TRIG_SOFT  = 2'h0;
   localparam logic [1:0]  CCS_TRIG_TIMER = 2'h1;
   localparam logic [1:0]  CCS_TRIG_SYNCA = 2'h2;
   localparam logic [1:0]  CCS_TRIG_SYNCB = 2'h3;

   // Reset values
   localparam logic [7:0]  CCS_RST_LENGTH = 8'h0f;
   localparam logic [7:0]  CCS_RST_LAG    = 8'h07;
   localparam logic [7:0]  CCS_RST_MASK   = 8'h00;
   localparam logic [15:0] CCS_RST_STAGE  = 16'h0000;

   // Canceler read phase to tap index; mirrored pulses walk back without repeating the last tap
   function automatic logic [7:0] ccs_tap_of(input logic [8:0] phase, input logic [7:0] len,
                                             input logic mirror);
      logic [8:0] back;
      back = {len, 1'b0} - 9'h002 - phase;
      if (mirror && (phase >= {1'b0, len}))
         ccs_tap_of = back[7:0];
      else
         ccs_tap_of = phase[7:0];
   endfunction : ccs_tap_of
endpackage : ccs_pkg

/* File: hw/ccs_ram_if.sv */
// Broadcast write path from the loader to the canceler RAMs
`timescale 1ns/10ps
interface ccs_ram_if;
   import ccs_pkg::*;
   logic [CCS_RAMS-1:0] wrSel;
   logic [CCS_AW-1:0]   wrAddr;
   logic [CCS_DW-1:0]   wrData;
   logic [1:0]          format;
   logic [7:0]          length;
   modport loader (output wrSel, output wrAddr, output wrData, output format, output length);
   modport ram    (input wrSel, input wrAddr, input wrData, input format, input length);
endinterface : ccs_ram_if
